// *** verilog/adsc_regs.svh ***
`ifndef ADSC_REGS_SVH
`define ADSC_REGS_SVH
// byte offsets on the register bus
`define ADSC_OFF_CTRL     12'h000
`define ADSC_OFF_CFG1     12'h004
`define ADSC_OFF_CFG2     12'h008
`define ADSC_OFF_RESH     12'h00C
`define ADSC_OFF_RESL     12'h010
`define ADSC_OFF_STAT     12'h014
// control register fields
`define ADSC_CTRL_ON      0
`define ADSC_CTRL_GO      1
`define ADSC_CTRL_CHS_LO  2
`define ADSC_CTRL_CHS_HI  5
// pin and reference register fields
`define ADSC_CFG1_PCFG_LO 0
`define ADSC_CFG1_PCFG_HI 3
`define ADSC_CFG1_PREF    4
`define ADSC_CFG1_NREF    5
// timing and format register fields
`define ADSC_CFG2_CS_LO   0
`define ADSC_CFG2_CS_HI   2
`define ADSC_CFG2_ACQ_LO  3
`define ADSC_CFG2_ACQ_HI  5
`define ADSC_CFG2_FMT     7
// status register fields
`define ADSC_STAT_DONE    0
// reset values
`define ADSC_PCFG_FUSE1   4'h0
`define ADSC_PCFG_FUSE0   4'h7
// conversion length in conversion-clock periods; rc divider in system clocks
`define ADSC_CONV_TAD     5'h0B
`define ADSC_RC_DIV       8'h1E
`endif

// *** verilog/adsc_top.sv ***
// Function
// - negative reference bit picks channel 2 pin when set, ground when clear.
// - positive reference bit picks channel 3 pin when set, supply when clear.
// - pin field 0-2 all analog; higher values turn channels 12 downward digital.
// - at power-on the pin field loads 0000 if fuse set, 0111 if clear.
// - channels 5 to 7 exist only on the larger package.
// - acquisition field selects 0,2,4,6,8,12,16,20 conversion-clock periods.
// - clock field selects osc/2,/8,/32,/4,/16,/64 or internal RC clock.
// - with RC clock, start of the clock waits one instruction cycle.
// - any reset restores registers except the result pair, disables converter, aborts conversion.
// - on completion load result, clear start bit, set done flag.
// - power-on reset leaves the result pair unmodified.
// - nonzero acquisition time is inserted between start and conversion.
// - result by successive approximation, one bit per conversion-clock period.
// - upper two pin-config bits and timing bit 6 read zero.
// - each conversion takes eleven conversion-clock periods.
// - clearing start mid-conversion aborts and keeps the previous result.
// - with programmed acquisition, start samples then converts automatically.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`include "adsc_regs.svh"

package adsc_pkg;
  typedef enum logic [1:0] {
    ADSC_IDLE  = 2'b00,
    ADSC_DELAY = 2'b01,
    ADSC_ACQ   = 2'b11,
    ADSC_CONV  = 2'b10
  } adsc_state_t;

  typedef struct packed {
    adsc_state_t state;
    logic        on;
    logic        go;
    logic [3:0]  chs;
    logic        nref;
    logic        pref;
    logic [3:0]  pcfg;
    logic        fmt;
    logic [2:0]  acq;
    logic [2:0]  cs;
    logic [9:0]  res;
    logic        done;
    logic [9:0]  sar;
    logic [3:0]  bitn;
    logic [4:0]  tadn;
    logic [7:0]  div;
    logic        tad;
    logic [1:0]  fuse_s;
    logic        por_done;
    logic [1:0]  por_s;
    logic [1:0]  por_wait;
    logic        sample;
    logic        pready;
    logic [31:0] prdata;
    logic [12:0] dig;
  } adsc_st_t;
endpackage

module adsc_top #(
  parameter int CHANNELS = 13
) (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RESET_I,
  // power-on indication and fuse
  input  wire logic        POR_I,
  input  wire logic        PORTB_ANALOG_FUSE_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic             PREADY_O,
  output logic [31:0]      PRDATA_O,
  output logic             PSLVERR_O,
  // analog core side
  input  wire logic        CMP_I,
  output logic [9:0]       SAR_DAC_O,
  output logic             SAMPLE_O,
  output logic [3:0]       CHANNEL_SELECT_O,
  output logic             NEG_REF_SELECT_O,
  output logic             POS_REF_SELECT_O,
  output logic [12:0]      DIGITAL_PIN_O,
  output logic             CONV_DONE_FLAG_O
);

  adsc_pkg::adsc_st_t st;
  adsc_pkg::adsc_st_t next_st;
  logic [7:0]         acq_len;
  logic [7:0]         div_len;
  logic               wr;
  logic               rd;
  // the comparator answers on our own dac code within the cycle, so it is
  // same-clock logic; a synchroniser would outlast the shortest conversion period
  logic [9:0]         bit_mask;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    case (st.acq)
      3'h1:    acq_len = 8'h02;
      3'h2:    acq_len = 8'h04;
      3'h3:    acq_len = 8'h06;
      3'h4:    acq_len = 8'h08;
      3'h5:    acq_len = 8'h0C;
      3'h6:    acq_len = 8'h10;
      3'h7:    acq_len = 8'h14;
      default: acq_len = 8'h00;
    endcase
    // full conversion-clock periods in system clocks; rc choice is a fixed slow divider
    case (st.cs)
      3'h0:    div_len = 8'h02;
      3'h4:    div_len = 8'h04;
      3'h1:    div_len = 8'h08;
      3'h5:    div_len = 8'h10;
      3'h2:    div_len = 8'h20;
      3'h6:    div_len = 8'h40;
      default: div_len = `ADSC_RC_DIV;
    endcase
  end

  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd = PSEL_I && !PENABLE_I && !PWRITE_I;

  always_comb begin
    next_st = st;
    next_st.fuse_s   = {st.fuse_s[0], PORTB_ANALOG_FUSE_I};
    next_st.por_s    = {st.por_s[0], POR_I};
    next_st.por_wait = {st.por_wait[0], 1'b1};
    next_st.pready   = PSEL_I && !PENABLE_I;
    // fuse taken once both synchronisers have settled, and only after a power-on
    if (st.por_wait[1] && !st.por_done) begin
      next_st.por_done = 1'b1;
      if (st.por_s[1]) begin
        next_st.pcfg = st.fuse_s[1] ? `ADSC_PCFG_FUSE1 : `ADSC_PCFG_FUSE0;
      end
    end
    // conversion clock enable: one-cycle pulse every div_len cycles
    next_st.tad = 1'b0;
    if (st.div >= div_len - 8'h01) begin
      next_st.div = 8'h00;
      next_st.tad = 1'b1;
    end else begin
      next_st.div = st.div + 8'h01;
    end
    bit_mask = 10'h200 >> st.bitn;
    case (st.state)
      adsc_pkg::ADSC_IDLE: begin
        next_st.tadn = 5'h00;
        if (st.go && st.on) begin
          next_st.div = 8'h00;
          // a pulse left from the free-running divider would shorten the first period
          next_st.tad = 1'b0;
          if (st.cs[1:0] == 2'b11) next_st.state = adsc_pkg::ADSC_DELAY;
          else if (acq_len != 8'h00) next_st.state = adsc_pkg::ADSC_ACQ;
          else next_st.state = adsc_pkg::ADSC_CONV;
          next_st.sar  = 10'h200;
          next_st.bitn = 4'h0;
        end
      end
      adsc_pkg::ADSC_DELAY: begin
        // one instruction cycle of four clocks before the rc clock starts
        next_st.div  = 8'h00;
        next_st.tad  = 1'b0;
        next_st.tadn = st.tadn + 5'h01;
        if (st.tadn == 5'h03) begin
          next_st.tadn  = 5'h00;
          next_st.state = (acq_len != 8'h00) ? adsc_pkg::ADSC_ACQ : adsc_pkg::ADSC_CONV;
        end
      end
      adsc_pkg::ADSC_ACQ: begin
        if (st.tad) begin
          next_st.tadn = st.tadn + 5'h01;
          if ({3'h0, st.tadn} == acq_len - 8'h01) begin
            next_st.tadn  = 5'h00;
            next_st.state = adsc_pkg::ADSC_CONV;
          end
        end
      end
      adsc_pkg::ADSC_CONV: begin
        if (st.tad) begin
          next_st.tadn = st.tadn + 5'h01;
          // first period is the hold, then one decision per period on the shown trial
          if (st.tadn != 5'h00 && st.bitn < 4'hA) begin
            if (!CMP_I) next_st.sar = st.sar & ~bit_mask;
            if (st.bitn < 4'h9) next_st.sar = next_st.sar | (bit_mask >> 1);
            next_st.bitn = st.bitn + 4'h1;
          end
          if (st.tadn == `ADSC_CONV_TAD - 5'h01) begin
            next_st.res   = next_st.sar;
            next_st.go    = 1'b0;
            next_st.done  = 1'b1;
            next_st.state = adsc_pkg::ADSC_IDLE;
          end
        end
      end
      default: next_st.state = adsc_pkg::ADSC_IDLE;
    endcase
    if (!st.go || !st.on) begin
      next_st.state = adsc_pkg::ADSC_IDLE;
    end
    next_st.sample = next_st.state != adsc_pkg::ADSC_CONV;
    if (wr) begin
      case (PADDR_I)
        `ADSC_OFF_CTRL: begin
          next_st.on  = PWDATA_I[`ADSC_CTRL_ON];
          next_st.go  = PWDATA_I[`ADSC_CTRL_GO];
          next_st.chs = PWDATA_I[`ADSC_CTRL_CHS_HI:`ADSC_CTRL_CHS_LO];
        end
        `ADSC_OFF_CFG1: begin
          next_st.nref = PWDATA_I[`ADSC_CFG1_NREF];
          next_st.pref = PWDATA_I[`ADSC_CFG1_PREF];
          next_st.pcfg = PWDATA_I[`ADSC_CFG1_PCFG_HI:`ADSC_CFG1_PCFG_LO];
        end
        `ADSC_OFF_CFG2: begin
          next_st.fmt = PWDATA_I[`ADSC_CFG2_FMT];
          next_st.acq = PWDATA_I[`ADSC_CFG2_ACQ_HI:`ADSC_CFG2_ACQ_LO];
          next_st.cs  = PWDATA_I[`ADSC_CFG2_CS_HI:`ADSC_CFG2_CS_LO];
        end
        `ADSC_OFF_RESH: begin
          if (st.fmt) next_st.res[9:8] = PWDATA_I[1:0];
          else next_st.res[9:2] = PWDATA_I[7:0];
        end
        `ADSC_OFF_RESL: begin
          if (st.fmt) next_st.res[7:0] = PWDATA_I[7:0];
          else next_st.res[1:0] = PWDATA_I[7:6];
        end
        // set wins over the write-one clear
        `ADSC_OFF_STAT: begin
          if (PWDATA_I[`ADSC_STAT_DONE] && !(next_st.done && !st.done)) next_st.done = 1'b0;
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (PADDR_I)
        `ADSC_OFF_CTRL: next_st.prdata = {26'h0, st.chs, st.go && st.on, st.on};
        `ADSC_OFF_CFG1: next_st.prdata = {26'h0, st.nref, st.pref, st.pcfg};
        `ADSC_OFF_CFG2: next_st.prdata = {24'h0, st.fmt, 1'b0, st.acq, st.cs};
        `ADSC_OFF_RESH: next_st.prdata = st.fmt ? {30'h0, st.res[9:8]}
                                                 : {24'h0, st.res[9:2]};
        `ADSC_OFF_RESL: next_st.prdata = st.fmt ? {24'h0, st.res[7:0]}
                                                 : {24'h0, st.res[1:0], 6'h00};
        `ADSC_OFF_STAT: next_st.prdata = {31'h0, st.done};
        default:        next_st.prdata = 32'h0;
      endcase
    end
    // pin mask: value v above 2 turns channels 12 down to 15-v digital
    for (int i = 0; i < 13; i++) begin
      next_st.dig[i] = (st.pcfg > 4'h2) && (i >= 15 - int'(st.pcfg));
    end
    // small package: channels 5..7 are absent and never analog
    if (CHANNELS < 13) next_st.dig[7:5] = 3'h7;
  end

  ////////////////////////////////////////////////////////////////
  // result is excluded from reset so a power-on leaves it alone
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st.state    <= adsc_pkg::ADSC_IDLE;
      st.on       <= 1'b0;
      st.go       <= 1'b0;
      st.chs      <= 4'h0;
      st.nref     <= 1'b0;
      st.pref     <= 1'b0;
      st.pcfg     <= `ADSC_PCFG_FUSE1;
      st.fmt      <= 1'b0;
      st.acq      <= 3'h0;
      st.cs       <= 3'h0;
      st.done     <= 1'b0;
      st.sar      <= 10'h000;
      st.bitn     <= 4'h0;
      st.tadn     <= 5'h00;
      st.div      <= 8'h00;
      st.tad      <= 1'b0;
      st.fuse_s   <= 2'b00;
      st.por_done <= 1'b0;
      st.por_s    <= 2'b00;
      st.por_wait <= 2'b00;
      st.sample   <= 1'b1;
      st.pready   <= 1'b0;
      st.prdata   <= 32'h0;
      st.dig      <= 13'h0000;
    end else begin
      st          <= next_st;
      st.res      <= next_st.res;
    end
  end

  ////////////////////////////////////////////////////////////////
  assign PREADY_O         = st.pready;
  assign PRDATA_O         = st.prdata;
  assign PSLVERR_O        = 1'b0;
  assign SAR_DAC_O        = st.sar;
  assign SAMPLE_O         = st.sample;
  assign CHANNEL_SELECT_O = st.chs;
  assign NEG_REF_SELECT_O = st.nref;
  assign POS_REF_SELECT_O = st.pref;
  assign DIGITAL_PIN_O    = st.dig;
  assign CONV_DONE_FLAG_O = st.done;

endmodule // adsc_top

// *** tb/adsc_assertions.sv ***
`timescale 1ns/100ps
`include "adsc_regs.svh"
module adsc_checker (
  // clock and reset
  input wire logic        MCLK_I,
  input wire logic        RESET_I,
  // register bus
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // analog side
  input wire logic        SAMPLE_O,
  input wire logic [3:0]  CHANNEL_SELECT_O,
  input wire logic        NEG_REF_SELECT_O,
  input wire logic        POS_REF_SELECT_O,
  input wire logic [12:0] DIGITAL_PIN_O,
  input wire logic        CONV_DONE_FLAG_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  logic wr;
  assign wr = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  ////////////////////////////////////////////////////////////
  a_ready_zero_wait:
    assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("pready late");
  a_ready_single:
    assert property (PREADY_O |=> !PREADY_O) else $error("pready held too long");
  a_no_slverr:
    assert property (!PSLVERR_O) else $error("unexpected slave error");
  a_ref_follow:
    assert property (wr && PADDR_I == `ADSC_OFF_CFG1 |=> NEG_REF_SELECT_O == $past(PWDATA_I[5])
      && POS_REF_SELECT_O == $past(PWDATA_I[4])) else $error("reference select wrong");
  a_pin_map:
    assert property (wr && PADDR_I == `ADSC_OFF_CFG1 |-> ##2
      DIGITAL_PIN_O == 13'(16'h1FFF << (4'hF - $past(PWDATA_I[3:0], 2))))
      else $error("digital pin map wrong");
  a_chan_follow:
    assert property (wr && PADDR_I == `ADSC_OFF_CTRL |=> CHANNEL_SELECT_O == $past(PWDATA_I[5:2]))
      else $error("channel select wrong");
  a_flag_sticky:
    assert property (CONV_DONE_FLAG_O && !(wr && PADDR_I == `ADSC_OFF_STAT && PWDATA_I[0])
      |=> CONV_DONE_FLAG_O) else $error("done flag lost");
  a_flag_idle:
    assert property ($rose(CONV_DONE_FLAG_O) |-> ##[0:2] SAMPLE_O) else $error("not sampling");
  a_conv_span:
    assert property ($fell(SAMPLE_O) |-> !SAMPLE_O [*8]) else $error("conversion too short");
endmodule // adsc_checker

bind adsc_top adsc_checker chk_u (.MCLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PWDATA_I, .PREADY_O, .PSLVERR_O, .SAMPLE_O, .CHANNEL_SELECT_O, .NEG_REF_SELECT_O,
  .POS_REF_SELECT_O, .DIGITAL_PIN_O, .CONV_DONE_FLAG_O);

// *** tb/adsc_analog_model.sv ***
`timescale 1ns/100ps
module adsc_analog_model (
  // converter side
  input  wire logic       sample_i,
  input  wire logic [9:0] dac_i,
  // stimulus
  input  wire logic [9:0] vin_i,
  output logic            cmp_o
);
  logic [9:0] held;
  // hold capacitor tracks only while sampling, so late input changes are not seen
  always_latch if (sample_i) held <= vin_i;
  assign cmp_o = held >= dac_i;
endmodule // adsc_analog_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`include "adsc_regs.svh"
module testbench;
  logic        clk = 0, rst = 1, fuse = 1, por = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] padr = 0;
  logic [31:0] pwd = 0, prd, r;
  logic [9:0]  dac, vin = 0;
  logic [12:0] dig;
  logic [3:0]  chs;
  logic        rdy, err, cmp, smp, nref, pref, flag;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  adsc_top dut_u (.MCLK_I(clk), .RESET_I(rst), .POR_I(por), .PORTB_ANALOG_FUSE_I(fuse),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PREADY_O(rdy), .PRDATA_O(prd), .PSLVERR_O(err), .CMP_I(cmp), .SAR_DAC_O(dac),
    .SAMPLE_O(smp), .CHANNEL_SELECT_O(chs), .NEG_REF_SELECT_O(nref),
    .POS_REF_SELECT_O(pref), .DIGITAL_PIN_O(dig), .CONV_DONE_FLAG_O(flag));
  adsc_analog_model ana_u (.sample_i(smp), .dac_i(dac), .vin_i(vin), .cmp_o(cmp));
  ////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    // only the watchdog ends a wait that never sees pready
    do @(posedge clk); while (rdy !== 1'b1);
    r = prd;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic rd(input logic [11:0] a, input string s, input logic [31:0] e);
    apb(0, a, 0);
    chk(s, e, r);
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_cfg;
    apb(1, `ADSC_OFF_CFG1, 32'hFF);
    rd(`ADSC_OFF_CFG1, "cfg1", 32'h3F);
    apb(1, `ADSC_OFF_CFG2, 32'hFF);
    rd(`ADSC_OFF_CFG2, "cfg2", 32'hBF);
    rd(12'h020, "unmapped", 0);
    chk("slverr", 0, 32'(err));
    for (int p = 0; p < 16; p++) begin
      apb(1, `ADSC_OFF_CFG1, 32'({p[0], p[1], p[3:0]}));
      repeat (2) @(posedge clk);
      chk("nref", 32'(p[0]), 32'(nref));
      chk("pref", 32'(p[1]), 32'(pref));
      chk("dig", 32'(13'(16'h1FFF << (15 - p))), 32'(dig));
    end
  endtask
  task automatic t_conv(input logic [2:0] cs, input logic [2:0] aq, input logic [9:0] v);
    int tad, at, t0;
    tad = cs[1:0] == 2'b11 ? 30 : 2 << (cs[1:0] * 2 + cs[2]);
    at = aq < 5 ? 2 * aq : 4 * aq - 8;
    vin <= v;
    apb(1, `ADSC_OFF_CFG2, 32'({cs[0], 1'b0, aq, cs}));
    apb(1, `ADSC_OFF_CTRL, 32'h0D);
    apb(1, `ADSC_OFF_CTRL, 32'h0F);
    t0 = cyc;
    do apb(0, `ADSC_OFF_CTRL, 0); while (r[1] === 1'b1 && cyc - t0 < 4000);
    chk("busy", 0, 32'(r[1]));
    chk("flag pin", 1, 32'(flag));
    chk("channel", 3, 32'(chs));
    chk("time low", 1, 32'(cyc - t0 >= (at + 10) * tad));
    chk("time high", 1, 32'(cyc - t0 <= (at + 12) * tad + 16));
    rd(`ADSC_OFF_STAT, "flag", 1);
    rd(`ADSC_OFF_RESH, "resh", cs[0] ? 32'(v[9:8]) : 32'(v[9:2]));
    rd(`ADSC_OFF_RESL, "resl", cs[0] ? 32'(v[7:0]) : 32'({v[1:0], 6'h0}));
    apb(1, `ADSC_OFF_STAT, 1);
    rd(`ADSC_OFF_STAT, "flag clear", 0);
    repeat (3 * tad) @(posedge clk);
  endtask
  task automatic t_abort;
    t_conv(3'h0, 3'h0, 10'h3C1);
    apb(1, `ADSC_OFF_CFG2, 32'h06);
    vin <= 10'h05A;
    apb(1, `ADSC_OFF_CTRL, 32'h0F);
    repeat (100) @(posedge clk);
    apb(1, `ADSC_OFF_CTRL, 32'h0D);
    repeat (700) @(posedge clk);
    rd(`ADSC_OFF_STAT, "abort flag", 0);
    rd(`ADSC_OFF_RESH, "abort resh", 32'hF0);
  endtask
  task automatic t_rst;
    apb(1, `ADSC_OFF_CTRL, 32'h0F);
    repeat (100) @(posedge clk);
    rst <= 1;
    fuse <= 0;
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (6) @(posedge clk);
    rd(`ADSC_OFF_CTRL, "ctrl", 0);
    rd(`ADSC_OFF_CFG2, "cfg2 reset", 0);
    rd(`ADSC_OFF_CFG1, "pin field", 32'h07);
    chk("dig reset", 32'h1F00, 32'(dig));
    rd(`ADSC_OFF_RESH, "resh kept", 32'hF0);
    repeat (700) @(posedge clk);
    rd(`ADSC_OFF_STAT, "no finish", 0);
    // a reset that is not a power-on leaves the pin field at its plain reset value
    por <= 0;
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (6) @(posedge clk);
    rd(`ADSC_OFF_CFG1, "pin field warm", 0);
    chk("dig warm", 0, 32'(dig));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (5) @(posedge clk);
    rd(`ADSC_OFF_CFG1, "pin field por", 0);
    rd(`ADSC_OFF_CTRL, "ctrl por", 0);
    t_cfg;
    for (int i = 0; i < 8; i++) t_conv(i[2:0], 3'h2, 10'h3FF - 10'(i * 73));
    for (int i = 0; i < 8; i++) t_conv(3'h0, i[2:0], 10'(i * 146));
    t_abort;
    t_rst;
    stop_test;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule // testbench
